// ### src/stc_pkg.sv
// constants, types and contract of the sixteen-bit timer/counter
//
// Contract
// - the mode (timer, synchronous counter, asynchronous counter) follows control bit 1 and the bypass bit.
// - with the internal source the count rises once per instruction cycle (one pclk), after prescaling.
// - with the external source (bit 1 = 1) the count rises on each rising edge of the count input, or of the oscillator pin if bit 3 = 1, after prescaling;
//   the code skips rising edges until the first falling edge after counter mode is switched on.
// - the count moves only while control bit 0 is 1; clearing it holds the value.
// - the special event trigger input clears the count.
// - while the low-power oscillator is enabled both oscillator pins are inputs and port reads of them give 0.
// - control bit 7 reads as 0 and ignores writes.
// - the count wraps from FFFFh to 0000h, setting the overflow flag; an interrupt needs the enable bit too.
// - read-only control bit 6 shows whether the system clock comes from the low-power oscillator.
// - control bit 3 enables the low-power oscillator; 0 shuts its inverter off.
// - with the external source, bypass 1 counts unsynchronised, bypass 0 synchronises after the prescaler.
package stc_pkg;
   localparam logic [7:0]  CTRL_OFF    = 8'h10;
   localparam logic [7:0]  COUNT_OFF   = 8'h14;
   localparam logic [7:0]  FLAG_OFF    = 8'h18;
   localparam logic [15:0] COUNT_RST   = 16'h0000;
   localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
   localparam int          STATUS_BIT  = 6;
   localparam int          FLAG_BIT    = 0;
   localparam int          IRQ_EN_BIT  = 1;
   localparam int          PS_W        = 3;

   typedef struct packed {
      logic [1:0] prescale;
      logic       osc_en;
      logic       sync_bypass;
      logic       clk_sel;
      logic       on;
   } stc_ctrl_s;

   localparam stc_ctrl_s CTRL_RST = '0;
endpackage : stc_pkg

// ### src/stc_prescaler.sv
// prescaler dividing the count clock ticks by 1, 2, 4 or 8
`timescale 1ns/1ps
module stc_prescaler #(
   parameter int W = stc_pkg::PS_W
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         clear,
   input  wire logic         tick_in,
   input  wire logic [1:0]   sel,
   output logic              tick_out
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] mask;

   // mask of low bits that must be all ones before a tick passes
   assign mask     = W'((1 << sel) - 1);
   assign tick_out = tick_in && ((cnt_q & mask) == mask);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
      end else if (clear) begin
         cnt_q <= '0;
      end else if (tick_in) begin
         cnt_q <= tick_out ? '0 : cnt_q + W'(1);
      end
   end

   property p_div_one;
      @(posedge pclk) disable iff (!presetn) (sel == 2'b00 && tick_in) |-> tick_out;
   endproperty
   a_div_one: assert property (p_div_one) else $error("1:1 prescale dropped a tick");

   property p_div_two;
      @(posedge pclk) disable iff (!presetn)
         (sel == 2'b01 && tick_out && !clear) ##1 (sel == 2'b01 && !clear)[*1] |-> !(tick_in && tick_out);
   endproperty
   a_div_two: assert property (p_div_two) else $error("1:2 prescale passed two ticks in a row");

   property p_clear;
      @(posedge pclk) disable iff (!presetn) clear |=> cnt_q == '0;
   endproperty
   a_clear: assert property (p_clear) else $error("prescaler not cleared");
endmodule : stc_prescaler

// ### src/stc_timer.sv
// sixteen-bit timer/counter with apb register access
`timescale 1ns/1ps
module stc_timer (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        external_count_input,
   input  wire logic        lp_osc_input_pin,
   input  wire logic        sysclk_from_lp_osc,
   input  wire logic        special_event_trigger,
   input  wire logic [1:0]  port_direction_bits,
   output logic             port_c_line_zero_oe,
   output logic             port_c_line_one_oe,
   output logic             port_c_line_zero_read,
   output logic             port_c_line_one_read,
   output logic             low_power_osc_enable,
   output logic             overflow_irq
);
   stc_pkg::stc_ctrl_s ctrl_q;
   logic [15:0]        count_q;
   logic               flag_q;
   logic               irq_en_q;
   logic [2:0]         meta_q;
   logic [2:0]         sync_q;
   logic               src_prev_q;
   logic               armed_q;
   logic               ptick_q;
   logic [31:0]        prdata_q;
   logic               pslverr_q;
   logic               pready_q;
   logic               oe0_q;
   logic               oe1_q;
   logic               rd0_q;
   logic               rd1_q;
   logic               osc_q;
   logic               irq_q;

   // decode
   wire setup     = psel && !penable;
   wire access_wr = psel && penable && pwrite;
   wire hit_ctrl  = paddr == stc_pkg::CTRL_OFF;
   wire hit_count = paddr == stc_pkg::COUNT_OFF;
   wire hit_flag  = paddr == stc_pkg::FLAG_OFF;
   wire hit_any   = hit_ctrl || hit_count || hit_flag;
   wire wr_ctrl   = access_wr && hit_ctrl;
   wire wr_count  = access_wr && hit_count;
   wire wr_flag   = access_wr && hit_flag;

   // synchronised pins: [2] count input, [1] oscillator input, [0] clock status
   wire ext_s     = sync_q[2];
   wire osc_in_s  = sync_q[1];
   wire status_s  = sync_q[0];

   // the oscillator input pin feeds the counter when the oscillator runs
   wire src_lvl   = ctrl_q.osc_en ? osc_in_s : ext_s;
   wire src_rise  = src_lvl && !src_prev_q;
   wire src_fall  = !src_lvl && src_prev_q;
   wire ext_mode  = ctrl_q.on && ctrl_q.clk_sel;
   wire tick_in   = ctrl_q.on && (ctrl_q.clk_sel ? (src_rise && armed_q) : 1'b1);
   wire presc_clr = special_event_trigger || wr_count;
   wire ptick;
   // bypass only matters in counter mode; internal ticks are already in step
   wire resync    = ctrl_q.clk_sel && !ctrl_q.sync_bypass;
   wire inc       = ctrl_q.on && (resync ? ptick_q : ptick);
   wire wrap      = inc && (count_q == stc_pkg::COUNT_MAX) && !presc_clr;

   wire [7:0]  ctrl_rd  = {1'b0, status_s, ctrl_q};
   wire [31:0] rd_mux   = hit_ctrl  ? {24'h000000, ctrl_rd} :
                          hit_count ? {16'h0000, count_q} :
                          hit_flag  ? {30'h00000000, irq_en_q, flag_q} : 32'h00000000;

   stc_prescaler #(
      .W        (stc_pkg::PS_W)
   ) u_presc (
      .pclk     (pclk),
      .presetn  (presetn),
      .clear    (presc_clr),
      .tick_in  (tick_in),
      .sel      (ctrl_q.prescale),
      .tick_out (ptick)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= 3'h0;
         sync_q <= 3'h0;
      end else begin
         meta_q <= {external_count_input, lp_osc_input_pin, sysclk_from_lp_osc};
         sync_q <= meta_q;
      end
   end

   // counter mode waits for a falling edge before the first rising one counts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_prev_q <= 1'b0;
         armed_q    <= 1'b0;
         ptick_q    <= 1'b0;
      end else begin
         src_prev_q <= src_lvl;
         armed_q    <= ext_mode && (armed_q || src_fall);
         // only a tick made in the resynchronised mode may be counted one cycle late
         ptick_q    <= ptick && resync && !presc_clr;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= stc_pkg::CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_q <= stc_pkg::stc_ctrl_s'(pwdata[5:0]);
      end
   end

   // special event beats a same-cycle software write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q <= stc_pkg::COUNT_RST;
      end else if (special_event_trigger) begin
         count_q <= stc_pkg::COUNT_RST;
      end else if (wr_count) begin
         count_q <= pwdata[15:0];
      end else if (inc) begin
         count_q <= count_q + 16'h0001;
      end
   end

   // flag is write-one-to-clear; a wrap in the clearing cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q   <= 1'b0;
         irq_en_q <= 1'b0;
      end else begin
         flag_q   <= wrap || (flag_q && !(wr_flag && pwdata[stc_pkg::FLAG_BIT]));
         irq_en_q <= wr_flag ? pwdata[stc_pkg::IRQ_EN_BIT] : irq_en_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= 32'h00000000;
         pslverr_q <= 1'b0;
         pready_q  <= 1'b0;
      end else begin
         pready_q <= 1'b1;
         if (setup) begin
            prdata_q  <= pwrite ? 32'h00000000 : rd_mux;
            pslverr_q <= !hit_any;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oe0_q <= 1'b0;
         oe1_q <= 1'b0;
         rd0_q <= 1'b0;
         rd1_q <= 1'b0;
         osc_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         oe0_q <= !port_direction_bits[0] && !ctrl_q.osc_en;
         oe1_q <= !port_direction_bits[1] && !ctrl_q.osc_en;
         rd0_q <= ext_s && !ctrl_q.osc_en;
         rd1_q <= osc_in_s && !ctrl_q.osc_en;
         osc_q <= ctrl_q.osc_en;
         irq_q <= flag_q && irq_en_q;
      end
   end

   assign prdata                = prdata_q;
   assign pslverr               = pslverr_q;
   assign pready                = pready_q;
   assign port_c_line_zero_oe   = oe0_q;
   assign port_c_line_one_oe    = oe1_q;
   assign port_c_line_zero_read = rd0_q;
   assign port_c_line_one_read  = rd1_q;
   assign low_power_osc_enable  = osc_q;
   assign overflow_irq          = irq_q;

   property p_timer_inc;
      @(posedge pclk) disable iff (!presetn)
         (ctrl_q.on && !ctrl_q.clk_sel && ctrl_q.prescale == 2'b00 && !presc_clr && !wr_ctrl)
         |=> count_q == $past(count_q) + 16'h0001;
   endproperty
   a_timer_inc: assert property (p_timer_inc) else $error("timer mode missed an increment");

   property p_hold_off;
      @(posedge pclk) disable iff (!presetn)
         (!ctrl_q.on && !presc_clr) |=> count_q == $past(count_q);
   endproperty
   a_hold_off: assert property (p_hold_off) else $error("count moved while off");

   property p_special;
      @(posedge pclk) disable iff (!presetn) special_event_trigger |=> count_q == 16'h0000 && !$rose(flag_q);
   endproperty
   a_special: assert property (p_special) else $error("special event did not clear count");

   property p_wrap;
      @(posedge pclk) disable iff (!presetn)
         wrap |=> (count_q == 16'h0000 && flag_q) ##1 (overflow_irq == $past(irq_en_q));
   endproperty
   a_wrap: assert property (p_wrap) else $error("wrap did not clear count and set flag");

   property p_ext_no_arm;
      @(posedge pclk) disable iff (!presetn)
         (ctrl_q.clk_sel && !armed_q && !presc_clr && !wr_ctrl) |=> count_q == $past(count_q);
   endproperty
   a_ext_no_arm: assert property (p_ext_no_arm) else $error("counter moved before first falling edge");

   property p_osc_pins;
      @(posedge pclk) disable iff (!presetn)
         ctrl_q.osc_en |=> !port_c_line_zero_oe && !port_c_line_one_oe && !port_c_line_zero_read
                           && !port_c_line_one_read && low_power_osc_enable;
   endproperty
   a_osc_pins: assert property (p_osc_pins) else $error("oscillator pins not forced to inputs");

   property p_bit7;
      @(posedge pclk) disable iff (!presetn) (setup && !pwrite && hit_ctrl) |=> prdata[7] == 1'b0;
   endproperty
   a_bit7: assert property (p_bit7) else $error("control bit 7 read as one");

   property p_status;
      @(posedge pclk) disable iff (!presetn) (setup && !pwrite && hit_ctrl) |=> prdata[6] == $past(status_s);
   endproperty
   a_status: assert property (p_status) else $error("clock status bit wrong");

   property p_sync_lag;
      @(posedge pclk) disable iff (!presetn)
         (resync && ctrl_q.on && ptick && !presc_clr && !wr_ctrl && !special_event_trigger)
         ##1 (!presc_clr && !wr_ctrl) |=> count_q == $past(count_q, 2) + 16'h0001;
   endproperty
   a_sync_lag: assert property (p_sync_lag) else $error("synchronised tick not counted one cycle later");
endmodule : stc_timer

// ### bench/stc_pin_model.sv
// far-side model: external count pin and low-power oscillator input pin
`timescale 1ns/1ps
module stc_pin_model (
   input  wire logic pclk,
   output logic      ext_pin,
   output logic      osc_pin
);
   // both idle high so every pulse offers its falling edge before the rising one
   initial begin
      ext_pin = 1'b1;
      osc_pin = 1'b1;
   end

   // three pclk per level keeps each level wide enough for the two-stage synchroniser
   task automatic pulses(input logic use_osc, input int n);
      repeat (n) begin
         repeat (3) @(posedge pclk);
         if (use_osc) osc_pin <= 1'b0;
         else ext_pin <= 1'b0;
         repeat (3) @(posedge pclk);
         if (use_osc) osc_pin <= 1'b1;
         else ext_pin <= 1'b1;
      end
   endtask : pulses
endmodule : stc_pin_model

// ### bench/tb_sixteen_bit_timer_counter.sv
// self-checking bench of the sixteen-bit timer/counter
`timescale 1ns/1ps
module tb_sixteen_bit_timer_counter;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, sysclk_lp, sev;
   logic        oe0, oe1, rd0, rd1, osc_en, irq, ext_pin, osc_pin;
   logic [1:0]  dir;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, r2;
   int          num_errors, checked, seed, p;

   stc_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .external_count_input(ext_pin), .lp_osc_input_pin(osc_pin), .sysclk_from_lp_osc(sysclk_lp),
      .special_event_trigger(sev), .port_direction_bits(dir), .port_c_line_zero_oe(oe0),
      .port_c_line_one_oe(oe1), .port_c_line_zero_read(rd0), .port_c_line_one_read(rd1),
      .low_power_osc_enable(osc_en), .overflow_irq(irq));
   stc_pin_model u_pin (.pclk(pclk), .ext_pin(ext_pin), .osc_pin(osc_pin));

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // returns at the edge that took the answer; read data lands in rd, the error in err
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         num_errors++;
         tally_and_finish();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      sysclk_lp = 1'b0;
      sev = 1'b0;
      dir = 2'h3;
      seed = 32'h184b2fb1;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, stc_pkg::CTRL_OFF + 8'(4 * i), 32'h0);
         chk(rd, 32'h0);
         chk({pready, err}, 2'b10);
      end
      $display("test reset done");
      for (int s = 0; s < 2; s++) begin
         sysclk_lp <= s[0];
         apb(1'b1, stc_pkg::CTRL_OFF, 32'hFF);
         apb(1'b0, stc_pkg::CTRL_OFF, 32'h0);
         chk(rd, {s[0], 6'h3F});
      end
      apb(1'b1, stc_pkg::CTRL_OFF, 32'h0);
      apb(1'b1, 8'h1C, 32'hFFFF);
      chk(err, 1'b1);
      apb(1'b0, 8'h1C, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      $display("test control done");
      p = $random(seed);
      apb(1'b1, stc_pkg::COUNT_OFF, p);
      apb(1'b0, stc_pkg::COUNT_OFF, 32'h0);
      chk(rd, p & 32'hFFFF);
      sev <= 1'b1;
      @(posedge pclk);
      sev <= 1'b0;
      apb(1'b0, stc_pkg::COUNT_OFF, 32'h0);
      chk(rd, 32'h0);
      $display("test event reset done");
      // a setup-to-setup gap of eight prescale periods must give exactly eight counts
      for (int ps = 0; ps < 4; ps++) begin
         apb(1'b1, stc_pkg::CTRL_OFF, 16 * ps + 1 + 4 * ($random(seed) & 1));
         repeat (16) @(posedge pclk);
         apb(1'b0, stc_pkg::COUNT_OFF, 32'h0);
         r2 = rd;
         repeat (8 * (1 << ps) - 3) @(posedge pclk);
         apb(1'b0, stc_pkg::COUNT_OFF, 32'h0);
         chk((rd - r2) & 32'hFFFF, 32'h8);
      end
      apb(1'b1, stc_pkg::CTRL_OFF, 32'h0);
      apb(1'b0, stc_pkg::COUNT_OFF, 32'h0);
      r2 = rd;
      repeat (5) @(posedge pclk);
      apb(1'b0, stc_pkg::COUNT_OFF, 32'h0);
      chk(rd, r2);
      $display("test timer done");
      apb(1'b1, stc_pkg::COUNT_OFF, 32'hFFF0);
      apb(1'b1, stc_pkg::CTRL_OFF, 32'h1);
      repeat (20) @(posedge pclk);
      apb(1'b0, stc_pkg::FLAG_OFF, 32'h0);
      chk(irq, 1'b0);
      chk(rd, 32'h1);
      apb(1'b1, stc_pkg::FLAG_OFF, 32'h2);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b1);
      apb(1'b1, stc_pkg::FLAG_OFF, 32'h3);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
      apb(1'b1, stc_pkg::CTRL_OFF, 32'h0);
      $display("test overflow done");
      // prescale, bypass and pin source all vary; the count write restarts the prescaler
      for (int i = 0; i < 4; i++) begin
         dir <= 2'($random(seed));
         apb(1'b1, stc_pkg::COUNT_OFF, 32'h0);
         apb(1'b1, stc_pkg::CTRL_OFF, 16 * i + 8 * i[1] + 4 * i[0] + 3);
         u_pin.pulses(i[1], 8);
         repeat (8) @(posedge pclk);
         chk(osc_en, i[1]);
         chk({oe1, oe0, rd1, rd0}, i[1] ? 4'h0 : {~dir[1], ~dir[0], 2'b11});
         apb(1'b1, stc_pkg::CTRL_OFF, 32'h0);
         apb(1'b0, stc_pkg::COUNT_OFF, 32'h0);
         chk(rd, 8 >> i);
      end
      $display("test counter done");
      tally_and_finish();
   end
endmodule : tb_sixteen_bit_timer_counter
